// ---- include/nsb_pkg.sv ----
// Package: constants and types for the nibble serial line bridge
package nsb_pkg;

	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int NIB_W = 4;
	localparam int ADDR_W = 8;
	localparam int JMP_W = 2;
	localparam int ADDR_HI_W = 6;

	// ----------------------------------------------------------------
	// Board selection: upper six address bits fixed
	// ----------------------------------------------------------------
	localparam logic [ADDR_HI_W-1:0] BOARD_ADDR_HI = 6'h30;
	localparam int ADDR_HI_LSB = 2;

	// ----------------------------------------------------------------
	// Write command nibbles
	// ----------------------------------------------------------------
	localparam logic [NIB_W-1:0] CMD_ADC_CLK_LO = 4'h0;
	localparam logic [NIB_W-1:0] CMD_ADC_CLK_HI = 4'h1;
	localparam logic [NIB_W-1:0] CMD_ADC_DIN_LO = 4'h2;
	localparam logic [NIB_W-1:0] CMD_ADC_DIN_HI = 4'h3;
	localparam logic [NIB_W-1:0] CMD_ADC_CS_LO = 4'h4;
	localparam logic [NIB_W-1:0] CMD_ADC_CS_HI = 4'h5;
	localparam logic [NIB_W-1:0] CMD_EE_SDA_LO = 4'h6;
	localparam logic [NIB_W-1:0] CMD_EE_SDA_HI = 4'h7;
	localparam logic [NIB_W-1:0] CMD_EE_SCL_LO = 4'h8;
	localparam logic [NIB_W-1:0] CMD_EE_SCL_HI = 4'h9;

	// ----------------------------------------------------------------
	// Read nibble field positions
	// ----------------------------------------------------------------
	localparam int RD_CONV_DONE_BIT = 3;
	localparam int RD_EE_SDA_BIT = 2;
	localparam int RD_ADC_DOUT_BIT = 1;
	localparam int RD_PRESENT_BIT = 0;
	localparam logic RD_PRESENT_VAL = 1'b0;

	// ----------------------------------------------------------------
	// Serial line levels after reset
	// ----------------------------------------------------------------
	localparam logic RST_ADC_CLK = 1'b0;
	localparam logic RST_ADC_DIN = 1'b0;
	localparam logic RST_ADC_CS = 1'b1;
	localparam logic RST_EE_SCL = 1'b1;
	localparam logic RST_EE_SDA_OE = 1'b0;
	localparam logic RST_EE_WP = 1'b0;

	// ----------------------------------------------------------------
	// Synchroniser layout: raw pin vector bit positions
	// ----------------------------------------------------------------
	localparam int SY_DATA_LSB = 0;
	localparam int SY_ADDR_LSB = 4;
	localparam int SY_JMP_LSB = 12;
	localparam int SY_WR_N = 14;
	localparam int SY_RD0_N = 15;
	localparam int SY_ADDR_STB_N = 16;
	localparam int SY_CONV_DONE = 17;
	localparam int SY_ADC_DOUT = 18;
	localparam int SY_EE_SDA = 19;
	localparam int SY_WP_JMP = 20;
	localparam int SY_W = 21;
	localparam logic [SY_W-1:0] SY_RST = 21'h01C000;

	// ----------------------------------------------------------------
	// Bus cycle states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00,
		CYC_WR = 2'b01,
		CYC_RD = 2'b10
	} nsb_cyc_t;

endpackage

// ---- include/nsb_sync_if.sv ----
// Interface: raw pin vector in, agreed synchronised vector out
`timescale 1ns/1ps
interface nsb_sync_if;
	logic [nsb_pkg::SY_W-1:0] raw;
	logic [nsb_pkg::SY_W-1:0] clean;

	modport src
	(
		output raw,
		input clean
	);

	modport snk
	(
		input raw,
		output clean
	);
endinterface

// ---- design/nsb_sync.sv ----
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module nsb_sync
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	nsb_sync_if.snk sy
);
	logic [nsb_pkg::SY_W-1:0] s1_q;
	logic [nsb_pkg::SY_W-1:0] s2_q;
	logic [nsb_pkg::SY_W-1:0] s3_q;
	logic [nsb_pkg::SY_W-1:0] clean_q;
	logic [nsb_pkg::SY_W-1:0] clean_d;

	// ----------------------------------------------------------------
	// Agreement filter, one bit each
	// ----------------------------------------------------------------
	// Stage one feeds stage two only; filtering looks at two and three
	genvar i;
	generate
		for (i = 0; i < nsb_pkg::SY_W; i++)
		begin : g_bit
			always_comb
			begin
				clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
			end
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			s1_q <= nsb_pkg::SY_RST;
			s2_q <= nsb_pkg::SY_RST;
			s3_q <= nsb_pkg::SY_RST;
			clean_q <= nsb_pkg::SY_RST;
		end
		else
		begin
			s1_q <= sy.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			clean_q <= clean_d;
		end
	end

	assign sy.clean = clean_q;
endmodule

// ---- design/nsb_bridge.sv ----
// Top: expansion bus nibble port driving converter and memory serial lines
`timescale 1ns/1ps
module nsb_bridge
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [7:0] BUS_ADDR_IN,
	input wire logic BUS_ADDR_STB_N_IN,
	input wire logic BUS_WR_N_IN,
	input wire logic BUS_RD0_N_IN,
	input wire logic [3:0] BUS_DATA_IN,
	output logic [3:0] BUS_DATA_OUT,
	output logic BUS_DATA_OE_OUT,
	input wire logic [1:0] ADDR_JMP_IN,
	input wire logic WP_JMP_IN,
	input wire logic CONV_DONE_IN,
	input wire logic ADC_DOUT_IN,
	output logic ADC_CLK_OUT,
	output logic ADC_DIN_OUT,
	output logic ADC_CS_OUT,
	output logic EE_SCL_OUT,
	input wire logic EE_SDA_IN,
	output logic EE_SDA_OUT,
	output logic EE_SDA_OE_OUT,
	output logic EE_WP_OUT,
	output logic SELECTED_OUT
);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	nsb_sync_if sy_bus();

	assign sy_bus.raw = {WP_JMP_IN, EE_SDA_IN, ADC_DOUT_IN, CONV_DONE_IN,
		BUS_ADDR_STB_N_IN, BUS_RD0_N_IN, BUS_WR_N_IN, ADDR_JMP_IN,
		BUS_ADDR_IN, BUS_DATA_IN};

	nsb_sync u_sync
	(
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.sy(sy_bus.snk)
	);

	logic [nsb_pkg::NIB_W-1:0] data_s;
	logic [nsb_pkg::ADDR_W-1:0] addr_s;
	logic [nsb_pkg::JMP_W-1:0] jmp_s;
	logic wr_s;
	logic rd0_s;
	logic addr_stb_s;
	logic conv_done_s;
	logic adc_dout_s;
	logic ee_sda_s;
	logic wp_jmp_s;

	// Strobes are active low at the pins, active high from here on
	always_comb
	begin
		data_s = sy_bus.clean[nsb_pkg::SY_DATA_LSB +: nsb_pkg::NIB_W];
		addr_s = sy_bus.clean[nsb_pkg::SY_ADDR_LSB +: nsb_pkg::ADDR_W];
		jmp_s = sy_bus.clean[nsb_pkg::SY_JMP_LSB +: nsb_pkg::JMP_W];
		wr_s = !sy_bus.clean[nsb_pkg::SY_WR_N];
		rd0_s = !sy_bus.clean[nsb_pkg::SY_RD0_N];
		addr_stb_s = !sy_bus.clean[nsb_pkg::SY_ADDR_STB_N];
		conv_done_s = sy_bus.clean[nsb_pkg::SY_CONV_DONE];
		adc_dout_s = sy_bus.clean[nsb_pkg::SY_ADC_DOUT];
		ee_sda_s = sy_bus.clean[nsb_pkg::SY_EE_SDA];
		wp_jmp_s = sy_bus.clean[nsb_pkg::SY_WP_JMP];
	end

	// ----------------------------------------------------------------
	// Board selection
	// ----------------------------------------------------------------
	logic sel_q;
	logic sel_d;
	logic addr_stb_q;
	logic addr_stb_d;

	// Selection is re-evaluated on each address strobe assertion
	always_comb
	begin
		sel_d = sel_q;
		addr_stb_d = addr_stb_s;
		if (addr_stb_s && !addr_stb_q)
		begin
			sel_d = (addr_s[nsb_pkg::ADDR_W-1:nsb_pkg::ADDR_HI_LSB] == nsb_pkg::BOARD_ADDR_HI)
				&& (addr_s[nsb_pkg::JMP_W-1:0] == jmp_s);
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			sel_q <= 1'b0;
			addr_stb_q <= 1'b0;
		end
		else
		begin
			sel_q <= sel_d;
			addr_stb_q <= addr_stb_d;
		end
	end

	// ----------------------------------------------------------------
	// Bus cycle tracking
	// ----------------------------------------------------------------
	nsb_pkg::nsb_cyc_t cyc_q;
	nsb_pkg::nsb_cyc_t cyc_d;
	logic wr_take;

	// One command per write strobe; a held strobe never repeats it
	always_comb
	begin
		cyc_d = cyc_q;
		wr_take = 1'b0;
		case (cyc_q)
			nsb_pkg::CYC_IDLE:
			begin
				if (wr_s)
				begin
					wr_take = sel_q;
					cyc_d = nsb_pkg::CYC_WR;
				end
				else if (rd0_s)
				begin
					cyc_d = nsb_pkg::CYC_RD;
				end
			end
			nsb_pkg::CYC_WR:
			begin
				if (!wr_s)
				begin
					cyc_d = nsb_pkg::CYC_IDLE;
				end
			end
			nsb_pkg::CYC_RD:
			begin
				if (!rd0_s)
				begin
					cyc_d = nsb_pkg::CYC_IDLE;
				end
			end
			default:
			begin
				cyc_d = nsb_pkg::CYC_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			cyc_q <= nsb_pkg::CYC_IDLE;
		end
		else
		begin
			cyc_q <= cyc_d;
		end
	end

	// ----------------------------------------------------------------
	// Serial control lines (write side of the port)
	// ----------------------------------------------------------------
	logic adc_clk_q;
	logic adc_clk_d;
	logic adc_din_q;
	logic adc_din_d;
	logic adc_cs_q;
	logic adc_cs_d;
	logic ee_scl_q;
	logic ee_scl_d;
	logic ee_sda_oe_q;
	logic ee_sda_oe_d;
	logic ee_wp_q;
	logic ee_wp_d;

	// Every line but protect keeps its level unless its own code arrives
	always_comb
	begin
		adc_clk_d = adc_clk_q;
		adc_din_d = adc_din_q;
		adc_cs_d = adc_cs_q;
		ee_scl_d = ee_scl_q;
		ee_sda_oe_d = ee_sda_oe_q;
		// Protect follows the jumper; the memory refuses upper-half writes
		ee_wp_d = wp_jmp_s;
		if (wr_take)
		begin
			case (data_s)
				nsb_pkg::CMD_ADC_CLK_LO: adc_clk_d = 1'b0;
				nsb_pkg::CMD_ADC_CLK_HI: adc_clk_d = 1'b1;
				nsb_pkg::CMD_ADC_DIN_LO: adc_din_d = 1'b0;
				nsb_pkg::CMD_ADC_DIN_HI: adc_din_d = 1'b1;
				nsb_pkg::CMD_ADC_CS_LO: adc_cs_d = 1'b0;
				nsb_pkg::CMD_ADC_CS_HI: adc_cs_d = 1'b1;
				// Open drain: low means drive, high means release
				nsb_pkg::CMD_EE_SDA_LO: ee_sda_oe_d = 1'b1;
				nsb_pkg::CMD_EE_SDA_HI: ee_sda_oe_d = 1'b0;
				nsb_pkg::CMD_EE_SCL_LO: ee_scl_d = 1'b0;
				nsb_pkg::CMD_EE_SCL_HI: ee_scl_d = 1'b1;
				default:
				begin
					adc_clk_d = adc_clk_q;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			adc_clk_q <= nsb_pkg::RST_ADC_CLK;
			adc_din_q <= nsb_pkg::RST_ADC_DIN;
			adc_cs_q <= nsb_pkg::RST_ADC_CS;
			ee_scl_q <= nsb_pkg::RST_EE_SCL;
			ee_sda_oe_q <= nsb_pkg::RST_EE_SDA_OE;
			ee_wp_q <= nsb_pkg::RST_EE_WP;
		end
		else
		begin
			adc_clk_q <= adc_clk_d;
			adc_din_q <= adc_din_d;
			adc_cs_q <= adc_cs_d;
			ee_scl_q <= ee_scl_d;
			ee_sda_oe_q <= ee_sda_oe_d;
			ee_wp_q <= ee_wp_d;
		end
	end

	// ----------------------------------------------------------------
	// Status nibble (read side of the port)
	// ----------------------------------------------------------------
	logic [nsb_pkg::NIB_W-1:0] rd_q;
	logic [nsb_pkg::NIB_W-1:0] rd_d;
	logic rd_oe_q;
	logic rd_oe_d;

	// Levels are sampled live each cycle the read strobe is held,
	// so a slow host sees the latest state when it latches
	always_comb
	begin
		rd_d = rd_q;
		rd_oe_d = (cyc_d == nsb_pkg::CYC_RD) && sel_q;
		if (rd_oe_d)
		begin
			rd_d[nsb_pkg::RD_CONV_DONE_BIT] = conv_done_s;
			rd_d[nsb_pkg::RD_EE_SDA_BIT] = ee_sda_s;
			rd_d[nsb_pkg::RD_ADC_DOUT_BIT] = adc_dout_s;
			// Absent boards leave the pulled-up line reading 1
			rd_d[nsb_pkg::RD_PRESENT_BIT] = nsb_pkg::RD_PRESENT_VAL;
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			rd_q <= 4'h0;
			rd_oe_q <= 1'b0;
		end
		else
		begin
			rd_q <= rd_d;
			rd_oe_q <= rd_oe_d;
		end
	end

	// ----------------------------------------------------------------
	// Output ports, all from flip-flops but the tied-low EE_SDA_OUT
	// ----------------------------------------------------------------
	assign BUS_DATA_OUT = rd_q;
	assign BUS_DATA_OE_OUT = rd_oe_q;
	assign ADC_CLK_OUT = adc_clk_q;
	assign ADC_DIN_OUT = adc_din_q;
	assign ADC_CS_OUT = adc_cs_q;
	assign EE_SCL_OUT = ee_scl_q;
	// Data level is always low; only the enable moves
	assign EE_SDA_OUT = 1'b0;
	assign EE_SDA_OE_OUT = ee_sda_oe_q;
	assign EE_WP_OUT = ee_wp_q;
	assign SELECTED_OUT = sel_q;

endmodule

// ---- bench/nsb_bridge_asserts.sv ----
// Checker: port-level properties of the bridge top
`timescale 1ns/1ps
module nsb_bridge_chk
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic BUS_WR_N_IN,
	input wire logic BUS_RD0_N_IN,
	input wire logic [3:0] BUS_DATA_OUT,
	input wire logic BUS_DATA_OE_OUT,
	input wire logic CONV_DONE_IN,
	input wire logic ADC_DOUT_IN,
	input wire logic EE_SDA_IN,
	input wire logic ADC_CLK_OUT,
	input wire logic ADC_DIN_OUT,
	input wire logic ADC_CS_OUT,
	input wire logic EE_SCL_OUT,
	input wire logic EE_SDA_OE_OUT,
	input wire logic SELECTED_OUT
);
	logic [3:0] wr_age_q;
	logic [3:0] rd_age_q;
	logic [3:0] in_age_q;
	logic [4:0] lines;
	assign lines = {ADC_CLK_OUT, ADC_DIN_OUT, ADC_CS_OUT, EE_SCL_OUT, EE_SDA_OE_OUT};
	// ----------------------------------------------------------------
	// Cycles since each cause; zero after reset since pins refill
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			wr_age_q <= 4'h0;
			rd_age_q <= 4'h0;
			in_age_q <= 4'h0;
		end
		else
		begin
			wr_age_q <= !BUS_WR_N_IN ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
			rd_age_q <= !BUS_RD0_N_IN ? 4'h0 : rd_age_q + {3'h0, rd_age_q != 4'hF};
			in_age_q <= $changed({CONV_DONE_IN, ADC_DOUT_IN, EE_SDA_IN}) ? 4'h0 :
				in_age_q + {3'h0, in_age_q != 4'hF};
		end
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	property p_oe_sel;
		BUS_DATA_OE_OUT |-> SELECTED_OUT;
	endproperty
	property p_bit0;
		BUS_DATA_OE_OUT |-> !BUS_DATA_OUT[0];
	endproperty
	property p_unsel;
		!SELECTED_OUT && $past(!SELECTED_OUT) |-> $stable(lines);
	endproperty
	property p_wr_cause;
		!$stable(lines) |-> wr_age_q < 4'h8;
	endproperty
	property p_rd_rise;
		$rose(BUS_DATA_OE_OUT) |-> rd_age_q == 4'h0;
	endproperty
	property p_rd_end;
		rd_age_q > 4'h8 |-> !BUS_DATA_OE_OUT;
	endproperty
	property p_done;
		BUS_DATA_OE_OUT && in_age_q > 4'h8 |-> BUS_DATA_OUT[3] == CONV_DONE_IN;
	endproperty
	property p_sda;
		BUS_DATA_OE_OUT && in_age_q > 4'h8 |-> BUS_DATA_OUT[2] == EE_SDA_IN;
	endproperty
	property p_dout;
		BUS_DATA_OE_OUT && in_age_q > 4'h8 |-> BUS_DATA_OUT[1] == ADC_DOUT_IN;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("read driven while unselected");
	a_bit0: assert property (p_bit0) else $error("presence bit not low");
	a_unsel: assert property (p_unsel) else $error("line moved while unselected");
	a_wr_cause: assert property (p_wr_cause) else $error("line moved without write");
	a_rd_rise: assert property (p_rd_rise) else $error("drive without read strobe");
	a_rd_end: assert property (p_rd_end) else $error("drive held after read");
	a_done: assert property (p_done) else $error("done bit wrong");
	a_sda: assert property (p_sda) else $error("memory data bit wrong");
	a_dout: assert property (p_dout) else $error("converter data bit wrong");
	c_sel: cover property ($rose(SELECTED_OUT));
	c_rd: cover property ($rose(BUS_DATA_OE_OUT));
	c_sda: cover property ($rose(EE_SDA_OE_OUT));
endmodule
bind nsb_bridge nsb_bridge_chk u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
	.BUS_WR_N_IN(BUS_WR_N_IN), .BUS_RD0_N_IN(BUS_RD0_N_IN), .BUS_DATA_OUT(BUS_DATA_OUT),
	.BUS_DATA_OE_OUT(BUS_DATA_OE_OUT), .CONV_DONE_IN(CONV_DONE_IN),
	.ADC_DOUT_IN(ADC_DOUT_IN), .EE_SDA_IN(EE_SDA_IN), .ADC_CLK_OUT(ADC_CLK_OUT),
	.ADC_DIN_OUT(ADC_DIN_OUT), .ADC_CS_OUT(ADC_CS_OUT), .EE_SCL_OUT(EE_SCL_OUT),
	.EE_SDA_OE_OUT(EE_SDA_OE_OUT), .SELECTED_OUT(SELECTED_OUT));

// ---- bench/nsb_host.sv ----
// Host model: expansion bus cycles towards the board
`timescale 1ns/1ps
module nsb_host
(
	input wire logic clk_in,
	input wire logic conv_done_in,
	input wire logic [3:0] rd_data_in,
	input wire logic rd_oe_in,
	output logic [7:0] addr_out,
	output logic stb_n_out,
	output logic wr_n_out,
	output logic rd0_n_out,
	output logic [3:0] data_out
);
	initial
	begin
		addr_out = 8'h00;
		stb_n_out = 1'b1;
		wr_n_out = 1'b1;
		rd0_n_out = 1'b1;
		data_out = 4'hF;
	end
	// Strobes low 7 and high 7 cycles: clears the pin filter both ways
	task automatic sel(input logic [7:0] a);
		addr_out = a;
		stb_n_out = 1'b0;
		repeat (7) @(negedge clk_in);
		stb_n_out = 1'b1;
		addr_out = ~a;
		repeat (7) @(negedge clk_in);
	endtask
	task automatic wr(input logic [3:0] n);
		if (n < 4'h6)
			while (!conv_done_in) @(negedge clk_in);
		data_out = n;
		wr_n_out = 1'b0;
		repeat (7) @(negedge clk_in);
		wr_n_out = 1'b1;
		data_out = ~n;
		repeat (7) @(negedge clk_in);
	endtask
	task automatic rd(output logic [3:0] d, output logic oe);
		rd0_n_out = 1'b0;
		repeat (7) @(negedge clk_in);
		d = rd_data_in;
		oe = rd_oe_in;
		rd0_n_out = 1'b1;
		repeat (7) @(negedge clk_in);
	endtask
endmodule

// ---- bench/tb.sv ----
// Testbench: command table, status reads, selection and reset cases
`timescale 1ns/1ps
module tb;
	logic clk, rst_n, done, dout, pull, wp, oe, sel, ee_wp, sda_oe, rd_oe, stb_n, wr_n, rd0_n;
	logic ck, din, cs, scl;
	logic [1:0] jmp;
	logic [3:0] rd_data, nib, wdata;
	logic [7:0] addr;
	logic [4:0] lines;
	int n_mismatch = 0;
	int n_compared = 0;
	// Command, then {clk, din, cs, scl, sda pull} expected after it
	logic [8:0] rows [16] = '{{4'h1, 5'h16}, {4'h3, 5'h1E}, {4'h4, 5'h1A}, {4'h6, 5'h1B},
		{4'hA, 5'h1B}, {4'hB, 5'h1B}, {4'hC, 5'h1B}, {4'hD, 5'h1B}, {4'hE, 5'h1B},
		{4'hF, 5'h1B}, {4'h8, 5'h19}, {4'h0, 5'h09}, {4'h2, 5'h01}, {4'h5, 5'h05},
		{4'h7, 5'h04}, {4'h9, 5'h06}};
	assign lines = {ck, din, cs, scl, sda_oe};
	nsb_host host (.clk_in(clk), .conv_done_in(done), .rd_data_in(rd_data), .rd_oe_in(rd_oe),
		.addr_out(addr), .stb_n_out(stb_n), .wr_n_out(wr_n), .rd0_n_out(rd0_n),
		.data_out(wdata));
	nsb_bridge uut (.CLK_IN(clk), .RST_N_IN(rst_n), .BUS_ADDR_IN(addr),
		.BUS_ADDR_STB_N_IN(stb_n), .BUS_WR_N_IN(wr_n), .BUS_RD0_N_IN(rd0_n),
		.BUS_DATA_IN(wdata), .BUS_DATA_OUT(rd_data), .BUS_DATA_OE_OUT(rd_oe),
		.ADDR_JMP_IN(jmp), .WP_JMP_IN(wp), .CONV_DONE_IN(done), .ADC_DOUT_IN(dout),
		.ADC_CLK_OUT(ck), .ADC_DIN_OUT(din), .ADC_CS_OUT(cs), .EE_SCL_OUT(scl),
		.EE_SDA_IN(!(sda_oe | pull)), .EE_SDA_OUT(), .EE_SDA_OE_OUT(sda_oe),
		.EE_WP_OUT(ee_wp), .SELECTED_OUT(sel));
	task automatic chk_vec(input string w, input logic [4:0] e, input logic [4:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk_bit(input string w, input logic e, input logic g);
		chk_vec(w, {4'h0, e}, {4'h0, g});
	endtask
	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole run is near 630 cycles
	initial
	begin
		#200us;
		n_mismatch++;
		test_done();
	end
	initial
	begin
		rst_n = 1'b0;
		{done, dout, pull, wp} = 4'h8;
		jmp = 2'h2;
		repeat (8) @(negedge clk);
		chk_vec("reset lines", 5'h06, lines);
		chk_vec("reset flags", 5'h00, {2'h0, sel, rd_oe, ee_wp});
		rst_n = 1'b1;
		host.sel(8'hC2);
		chk_bit("selected", 1'b1, sel);
		foreach (rows[i])
		begin
			host.wr(rows[i][8:5]);
			chk_vec("lines", rows[i][4:0], lines);
		end
		$display("command table done");
		for (int i = 0; i < 8; i++)
		begin
			{done, dout, pull} = 3'(i);
			repeat (12) @(negedge clk);
			host.rd(nib, oe);
			chk_vec("status", {1'h0, i[2], !i[0], i[1], 1'b0}, {1'h0, nib});
			chk_bit("drive", 1'b1, oe);
		end
		pull = 1'b0;
		$display("status reads done");
		wp = ~wp;
		repeat (8) @(negedge clk);
		chk_bit("protect pin", 1'b1, ee_wp);
		host.sel(8'hC1);
		chk_bit("wrong jumpers", 1'b0, sel);
		host.wr(4'h1);
		chk_vec("ignored write", 5'h06, lines);
		host.rd(nib, oe);
		chk_bit("ignored read", 1'b0, oe);
		host.sel(8'hC6);
		chk_bit("wrong upper bits", 1'b0, sel);
		$display("selection done");
		host.sel(8'hC2);
		host.wr(4'h1);
		chk_vec("before reset", 5'h16, lines);
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		chk_vec("mid reset", 5'h06, lines);
		chk_bit("mid reset select", 1'b0, sel);
		rst_n = 1'b1;
		$display("second reset done");
		// Every jumper setting, so the low address bits are really compared
		for (int j = 0; j < 4; j++)
		begin
			jmp = 2'(j);
			host.sel(8'hC0 + 8'(j));
			chk_bit("jumper select", 1'b1, sel);
		end
		host.wr(4'h3);
		chk_vec("after reset", 5'h0E, lines);
		wp = ~wp;
		repeat (8) @(negedge clk);
		chk_bit("protect off", 1'b0, ee_wp);
		$display("jumper select done");
		test_done();
	end
endmodule
